// ### core/clk_src_defines.vh
// Purpose: Constants shared by the clock source control block.
// Assumes: Included by its bare name from every design file that needs it.
// Notes:   Definitions only; no logic lives here.
`ifndef CLK_SRC_DEFINES_VH
`define CLK_SRC_DEFINES_VH

// ==========================================================================
// Register byte offsets on the AHB-Lite slave.
// ==========================================================================
`define OFS_PROC_CLK     8'h00
`define OFS_MAIN_MODE    8'h04
`define OFS_RING_CTRL    8'h08
`define OFS_MAIN_OSC     8'h0c
`define OFS_OSC_MODE     8'h10
`define OFS_SETTLE_SEL   8'h14
`define ADDR_BITS        8

// ==========================================================================
// Field positions.
// ==========================================================================
`define PCC_DIV_LSB      0
`define PCC_CSS_BIT      4
`define PCC_CLS_BIT      5
`define PCC_SUB_START_BIT_BIT  6
`define MCM_MODE_BIT     0
`define MCM_MCS_BIT      1
`define MCM_MAIN_SOURCE_SELECT_BIT_BIT     2
`define RCM_HALT_BIT     0
`define RCM_STABLE_BIT   7
`define MOC_HALT_BIT     7
`define OSC_EXCLK_BIT    7
`define OSC_OSCSEL_BIT   6
`define OSC_EXTERNAL_SUB_CLOCK_BIT_BIT   5
`define OSC_SUB_OSC_SELECT_BIT_BIT  4
`define SETTLE_LSB       0

// ==========================================================================
// Reset values and encodings.
// ==========================================================================
`define DIV_RESET        3'h1
`define DIV_MAX          3'h4
`define SETTLE_RESET     3'h5
`define MOC_HALT_RESET   1'h1
`define HTRANS_NONSEQ_B  1
`define WORD_ZERO        32'h0000_0000

// ==========================================================================
// Timing.
// ==========================================================================
`define CLK_MHZ          250
`define RING_SETTLE_NS   2000
`define SWITCH_GAP_CYC   4'h8

`endif

// ### core/cpu_clk_switch.v
// Purpose: Glitch-free handover of CPU, main and peripheral clock selection.
// Assumes: All requests come from logic on clk_i.
// Notes:   The gate drops before any selection changes and rises only after.
`timescale 1ns/1ps
`include "clk_src_defines.vh"

module cpu_clk_switch (
  input  wire       clk_i,         // Block clock.
  input  wire       arst_n_i,      // Asynchronous reset, active low.
  input  wire       req_main_hi_i, // Requested main clock from high-speed source.
  input  wire       req_per_hi_i,  // Requested peripheral clock from high-speed.
  input  wire       req_sub_i,     // Requested CPU clock from subsystem.
  input  wire [2:0] req_div_i,     // Requested divide code.
  output reg        main_hi_o,     // Applied main clock selection.
  output reg        per_hi_o,      // Applied peripheral clock selection.
  output reg        cpu_sub_o,     // Applied CPU source selection.
  output reg  [2:0] div_o,         // Applied divide code.
  output reg        gate_o         // High while the CPU clock may run.
);

  // ========================================================================
  // States.
  // ========================================================================
  localparam [1:0] ST_RUN   = 2'h0; // Selection stable, clock gated on.
  localparam [1:0] ST_QUIET = 2'h1; // Clock gated off, old source drains.
  localparam [1:0] ST_SETTLE = 2'h2; // New source applied, waiting to ungate.

  reg [1:0] state_q;   // Current state.
  reg [3:0] gap_q;     // Cycles left in a quiet or settle phase.
  wire      differs;   // Request differs from what is applied.

  assign differs = (req_main_hi_i != main_hi_o) || (req_per_hi_i != per_hi_o) ||
                   (req_sub_i != cpu_sub_o) || (req_div_i != div_o);

  // ========================================================================
  // Handover sequence: gate off, wait, switch, wait, gate on. Flags follow
  // the applied selection, so they never claim a source before it runs.
  // ========================================================================
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q   <= ST_RUN;
      gap_q     <= 4'h0;
      main_hi_o <= 1'b0;     // Ring oscillator feeds everything after reset.
      per_hi_o  <= 1'b0;
      cpu_sub_o <= 1'b0;
      div_o     <= `DIV_RESET;
      gate_o    <= 1'b1;
    end else begin
      case (state_q)
        ST_RUN: begin
          // A changed request first stops the clock at a whole cycle.
          if (differs) begin
            gate_o  <= 1'b0;
            gap_q   <= `SWITCH_GAP_CYC;
            state_q <= ST_QUIET;
          end
        end
        ST_QUIET: begin
          if (gap_q == 4'h0) begin
            // Take a fresh copy, so a request that moved again still lands.
            main_hi_o <= req_main_hi_i;
            per_hi_o  <= req_per_hi_i;
            cpu_sub_o <= req_sub_i;
            div_o     <= req_div_i;
            gap_q     <= `SWITCH_GAP_CYC;
            state_q   <= ST_SETTLE;
          end else begin
            gap_q <= gap_q - 4'h1;
          end
        end
        ST_SETTLE: begin
          if (gap_q == 4'h0) begin
            gate_o  <= 1'b1;
            state_q <= ST_RUN;
          end else begin
            gap_q <= gap_q - 4'h1;
          end
        end
        default: begin
          state_q <= ST_RUN;
          gate_o  <= 1'b1;
        end
      endcase
    end
  end

endmodule // cpu_clk_switch

// ### core/clock_source_ctrl.v
// Purpose: Clock source control of a small controller, reached over AHB-Lite.
// Assumes: Oscillators sit outside and follow the run and enable outputs.
// Notes:   Registers answer with zero wait states; responses are always OKAY.
//
// Functional notes
// - Stop instruction halts main crystal or input
// - Two flags report the active CPU source
// - Main halt bit stops crystal or input
// - Clearing ring halt bit starts ring oscillator
// - Accuracy flag rises after settle time
// - Ring oscillator runs and feeds CPU after reset
// - Select and mode bits choose main/peripheral clocks
// - Source select 0 feeds divided main clock
// - Three-bit divide code, others prohibited
// - Stop instruction halts ring oscillator too
// - Setting ring halt bit stops ring oscillator
// - Sub pins start in port mode
// - Two bit patterns enable sub crystal mode
// - Unused sub pins stay port pins
// - Both bits set: high-speed clock everywhere
// - Clearing main halt starts crystal or input
// - Source select 1 feeds subsystem clock
// - Clearing sub select halts sub oscillator; here it keeps running while the sub start bit is set
`timescale 1ns/1ps
`include "clk_src_defines.vh"

module clock_source_ctrl (
  input  wire        clk_i,              // Block clock, 250 MHz.
  input  wire        arst_n_i,           // Asynchronous reset, active low.
  input  wire        hsel_i,             // AHB slave select.
  input  wire [31:0] haddr_i,            // AHB address.
  input  wire [1:0]  htrans_i,           // AHB transfer type.
  input  wire        hwrite_i,           // AHB write strobe.
  input  wire [2:0]  hsize_i,            // AHB size, word only.
  input  wire [31:0] hwdata_i,           // AHB write data.
  input  wire        hready_i,           // AHB bus ready.
  output reg  [31:0] hrdata_o,           // AHB read data.
  output reg         hreadyout_o,        // AHB slave ready.
  output reg         hresp_o,            // AHB response, always OKAY.
  input  wire        stop_req_i,         // One-cycle stop-mode instruction pulse.
  input  wire        wake_i,             // Standby release pin, asynchronous.
  output reg         stop_mode_o,        // Device is in stop mode.
  output reg         main_crystal_osc_o, // Main crystal oscillator runs.
  output reg         main_ext_in_en_o,   // External main clock input enabled.
  output reg         ring_osc_run_o,     // High-speed ring oscillator runs.
  output reg         sub_crystal_osc_o,  // Sub pins in crystal oscillation mode.
  output reg         sub_ext_in_en_o,    // Sub pins take an external clock.
  output reg         main_clk_hi_o,      // Main clock from high-speed source.
  output reg         per_clk_hi_o,       // Peripheral clock from high-speed.
  output reg         cpu_on_sub_o,       // CPU clock from subsystem.
  output reg  [2:0]  cpu_div_o,          // Applied divide code.
  output reg         cpu_clk_gate_o,     // CPU clock enabled, low during handover.
  output reg  [2:0]  settle_sel_o        // Post-standby settle selection.
);

  // ========================================================================
  // Timing counts.
  // ========================================================================
  // A least time, so the cycle count rounds up.
  localparam integer RING_CYC = (`RING_SETTLE_NS * `CLK_MHZ + 999) / 1000;
  localparam [11:0]  RING_END = RING_CYC[11:0];

  // ========================================================================
  // Software-visible state.
  // ========================================================================
  reg        cpu_source_select_bit_q;  // CPU from subsystem when set.
  reg [2:0]  cpu_div_q;                // Requested divide code.
  reg        sub_start_bit_q;          // Forces sub crystal mode.
  reg        main_source_select_bit_q; // High-speed source selected.
  reg        main_clock_mode_bit_q;    // Main clock also from high-speed.
  reg        ring_osc_halt_bit_q;      // Ring oscillator halted.
  reg        ring_accuracy_stable_q;   // Ring accuracy reached.
  reg        main_osc_halt_bit_q;      // Main oscillator halted.
  reg        exclk_q;                  // Main pins take external clock.
  reg        oscsel_q;                 // Main pins in clock mode.
  reg        external_sub_clock_bit_q; // Sub pins take external clock.
  reg        sub_osc_select_bit_q;     // Sub pins in clock mode.
  reg [2:0]  settle_q;                 // Post-standby settle selection.
  reg        stop_q;                   // Stop mode active.
  reg [11:0] ring_cnt_q;               // Ring accuracy settle counter.

  // Bus data phase bookkeeping.
  reg                   wr_pend_q;     // A write data phase is due.
  reg [`ADDR_BITS-1:0]  wr_addr_q;     // Its address.

  // Wake pin synchroniser; only the second stage is read by logic.
  reg wake_s1_q;
  reg wake_s2_q;

  // Applied selection from the switch.
  wire       sw_main_hi;
  wire       sw_per_hi;
  wire       sw_sub;
  wire [2:0] sw_div;
  wire       sw_gate;

  wire addr_phase;                     // Valid address phase taken this edge.
  assign addr_phase = hsel_i && hready_i && htrans_i[`HTRANS_NONSEQ_B];

  // Decides whether a divide code is one of the five legal ones.
  function div_legal;
    input [2:0] code;
    begin
      div_legal = (code <= `DIV_MAX);
    end
  endfunction

  // ========================================================================
  // Wake pin synchroniser.
  // ========================================================================
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
    end else begin
      wake_s1_q <= wake_i;
      wake_s2_q <= wake_s1_q;
    end
  end

  // ========================================================================
  // Register writes, taken in the data phase after the address phase.
  // ========================================================================
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_pend_q                <= 1'b0;
      wr_addr_q                <= {`ADDR_BITS{1'b0}};
      cpu_source_select_bit_q  <= 1'b0;
      cpu_div_q                <= `DIV_RESET;
      sub_start_bit_q          <= 1'b0;
      main_source_select_bit_q <= 1'b0;
      main_clock_mode_bit_q    <= 1'b0;
      ring_osc_halt_bit_q      <= 1'b0;
      main_osc_halt_bit_q      <= `MOC_HALT_RESET;
      exclk_q                  <= 1'b0;
      oscsel_q                 <= 1'b0;
      external_sub_clock_bit_q <= 1'b0;
      sub_osc_select_bit_q     <= 1'b0;
      settle_q                 <= `SETTLE_RESET;
    end else begin
      wr_pend_q <= addr_phase && hwrite_i;
      if (addr_phase) begin
        wr_addr_q <= haddr_i[`ADDR_BITS-1:0];
      end
      // The flags that software must check first are its own duty.
      if (wr_pend_q) begin
        if (wr_addr_q == `OFS_PROC_CLK) begin
          cpu_source_select_bit_q <= hwdata_i[`PCC_CSS_BIT];
          sub_start_bit_q         <= hwdata_i[`PCC_SUB_START_BIT_BIT];
          // A prohibited code is dropped; the last legal one stays.
          if (div_legal(hwdata_i[`PCC_DIV_LSB+2:`PCC_DIV_LSB])) begin
            cpu_div_q <= hwdata_i[`PCC_DIV_LSB+2:`PCC_DIV_LSB];
          end
        end else if (wr_addr_q == `OFS_MAIN_MODE) begin
          main_source_select_bit_q <= hwdata_i[`MCM_MAIN_SOURCE_SELECT_BIT_BIT];
          main_clock_mode_bit_q    <= hwdata_i[`MCM_MODE_BIT];
        end else if (wr_addr_q == `OFS_RING_CTRL) begin
          ring_osc_halt_bit_q <= hwdata_i[`RCM_HALT_BIT];
        end else if (wr_addr_q == `OFS_MAIN_OSC) begin
          main_osc_halt_bit_q <= hwdata_i[`MOC_HALT_BIT];
        end else if (wr_addr_q == `OFS_OSC_MODE) begin
          exclk_q                  <= hwdata_i[`OSC_EXCLK_BIT];
          oscsel_q                 <= hwdata_i[`OSC_OSCSEL_BIT];
          external_sub_clock_bit_q <= hwdata_i[`OSC_EXTERNAL_SUB_CLOCK_BIT_BIT];
          sub_osc_select_bit_q     <= hwdata_i[`OSC_SUB_OSC_SELECT_BIT_BIT];
        end else if (wr_addr_q == `OFS_SETTLE_SEL) begin
          settle_q <= hwdata_i[`SETTLE_LSB+2:`SETTLE_LSB];
        end
      end
    end
  end

  // ========================================================================
  // Register reads; data are registered at the address phase so that they
  // stand in the data phase. Unmapped offsets read zero.
  // ========================================================================
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hrdata_o    <= `WORD_ZERO;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (addr_phase && !hwrite_i) begin
        hrdata_o <= `WORD_ZERO;
        if (haddr_i[`ADDR_BITS-1:0] == `OFS_PROC_CLK) begin
          hrdata_o[`PCC_DIV_LSB+2:`PCC_DIV_LSB] <= cpu_div_q;
          hrdata_o[`PCC_CSS_BIT]     <= cpu_source_select_bit_q;
          hrdata_o[`PCC_CLS_BIT]     <= sw_sub;
          hrdata_o[`PCC_SUB_START_BIT_BIT] <= sub_start_bit_q;
        end else if (haddr_i[`ADDR_BITS-1:0] == `OFS_MAIN_MODE) begin
          hrdata_o[`MCM_MODE_BIT] <= main_clock_mode_bit_q;
          hrdata_o[`MCM_MCS_BIT]  <= sw_main_hi;
          hrdata_o[`MCM_MAIN_SOURCE_SELECT_BIT_BIT] <= main_source_select_bit_q;
        end else if (haddr_i[`ADDR_BITS-1:0] == `OFS_RING_CTRL) begin
          hrdata_o[`RCM_HALT_BIT]   <= ring_osc_halt_bit_q;
          hrdata_o[`RCM_STABLE_BIT] <= ring_accuracy_stable_q;
        end else if (haddr_i[`ADDR_BITS-1:0] == `OFS_MAIN_OSC) begin
          hrdata_o[`MOC_HALT_BIT] <= main_osc_halt_bit_q;
        end else if (haddr_i[`ADDR_BITS-1:0] == `OFS_OSC_MODE) begin
          hrdata_o[`OSC_EXCLK_BIT]   <= exclk_q;
          hrdata_o[`OSC_OSCSEL_BIT]  <= oscsel_q;
          hrdata_o[`OSC_EXTERNAL_SUB_CLOCK_BIT_BIT]  <= external_sub_clock_bit_q;
          hrdata_o[`OSC_SUB_OSC_SELECT_BIT_BIT] <= sub_osc_select_bit_q;
        end else if (haddr_i[`ADDR_BITS-1:0] == `OFS_SETTLE_SEL) begin
          hrdata_o[`SETTLE_LSB+2:`SETTLE_LSB] <= settle_q;
        end
      end
    end
  end

  // ========================================================================
  // Stop mode: entered on the instruction, left on the synchronised wake.
  // Entry wins when both land in one cycle, so no instruction is lost.
  // ========================================================================
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stop_q <= 1'b0;
    end else if (stop_req_i) begin
      stop_q <= 1'b1;
    end else if (wake_s2_q) begin
      stop_q <= 1'b0;
    end
  end

  // ========================================================================
  // Ring oscillator accuracy: counts from each restart; a halt or stop
  // clears the flag, since accuracy is lost while the oscillator is off.
  // ========================================================================
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ring_cnt_q             <= 12'h000;
      ring_accuracy_stable_q <= 1'b0;
    end else if (ring_osc_halt_bit_q || stop_q) begin
      ring_cnt_q             <= 12'h000;
      ring_accuracy_stable_q <= 1'b0;
    end else if (ring_cnt_q == RING_END) begin
      ring_accuracy_stable_q <= 1'b1;
    end else begin
      ring_cnt_q <= ring_cnt_q + 12'h001;
    end
  end

  // ========================================================================
  // Glitch-free selection handover.
  // ========================================================================
  cpu_clk_switch u_switch (
    .clk_i         (clk_i),
    .arst_n_i      (arst_n_i),
    .req_main_hi_i (main_source_select_bit_q && main_clock_mode_bit_q),
    .req_per_hi_i  (main_source_select_bit_q),
    .req_sub_i     (cpu_source_select_bit_q),
    .req_div_i     (cpu_div_q),
    .main_hi_o     (sw_main_hi),
    .per_hi_o      (sw_per_hi),
    .cpu_sub_o     (sw_sub),
    .div_o         (sw_div),
    .gate_o        (sw_gate)
  );

  // ========================================================================
  // Output flops: oscillator enables, pin modes and clock selection.
  // ========================================================================
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stop_mode_o        <= 1'b0;
      main_crystal_osc_o <= 1'b0;
      main_ext_in_en_o   <= 1'b0;
      ring_osc_run_o     <= 1'b1;
      sub_crystal_osc_o  <= 1'b0;
      sub_ext_in_en_o    <= 1'b0;
      main_clk_hi_o      <= 1'b0;
      per_clk_hi_o       <= 1'b0;
      cpu_on_sub_o       <= 1'b0;
      cpu_div_o          <= `DIV_RESET;
      cpu_clk_gate_o     <= 1'b1;
      settle_sel_o       <= `SETTLE_RESET;
    end else begin
      stop_mode_o        <= stop_q;
      // Crystal when not in external mode, input gate when it is.
      main_crystal_osc_o <= !main_osc_halt_bit_q && !stop_q &&
                            oscsel_q && !exclk_q;
      main_ext_in_en_o   <= !main_osc_halt_bit_q && !stop_q &&
                            oscsel_q && exclk_q;
      ring_osc_run_o     <= !ring_osc_halt_bit_q && !stop_q;
      // Sub oscillation is not stopped by stop mode.
      sub_crystal_osc_o  <= sub_start_bit_q ||
                            (!external_sub_clock_bit_q && sub_osc_select_bit_q);
      // Otherwise the pins stay plain port pins.
      sub_ext_in_en_o    <= !sub_start_bit_q && external_sub_clock_bit_q &&
                            sub_osc_select_bit_q;
      main_clk_hi_o      <= sw_main_hi;
      per_clk_hi_o       <= sw_per_hi;
      cpu_on_sub_o       <= sw_sub;
      cpu_div_o          <= sw_div;
      cpu_clk_gate_o     <= sw_gate;
      settle_sel_o       <= settle_q;
    end
  end

endmodule // clock_source_ctrl

// ### testbench/clock_source_ctrl_props.sv
// Purpose: Port assertions for the clock source control block.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes:   Attached by bind to every instance of the block.
`timescale 1ns/1ps
module clock_source_ctrl_props (
  input logic       clk_i,
  input logic       arst_n_i,
  input logic       stop_req_i,
  input logic       stop_mode_o,
  input logic       main_crystal_osc_o,
  input logic       main_ext_in_en_o,
  input logic       ring_osc_run_o,
  input logic       sub_crystal_osc_o,
  input logic       sub_ext_in_en_o,
  input logic       main_clk_hi_o,
  input logic       per_clk_hi_o,
  input logic       cpu_on_sub_o,
  input logic [2:0] cpu_div_o,
  input logic       cpu_clk_gate_o
);
  // ==========================================================
  // All checks share the block clock and its reset.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_stop; stop_req_i |-> ##2 stop_mode_o && !ring_osc_run_o; endproperty
  a_stop: assert property (p_stop)
    else $error("stop request did not halt the ring oscillator");
  property p_halt; stop_mode_o |-> !main_crystal_osc_o && !main_ext_in_en_o; endproperty
  a_halt: assert property (p_halt)
    else $error("main source runs in stop mode");
  property p_main; !(main_crystal_osc_o && main_ext_in_en_o); endproperty
  a_main: assert property (p_main)
    else $error("crystal and external main input both on");
  property p_sub; !(sub_crystal_osc_o && sub_ext_in_en_o); endproperty
  a_sub: assert property (p_sub)
    else $error("sub pins in two modes at once");
  property p_per; main_clk_hi_o |-> per_clk_hi_o; endproperty
  a_per: assert property (p_per)
    else $error("peripheral clock not high-speed with main clock");
  property p_div; cpu_div_o <= 3'h4; endproperty
  a_div: assert property (p_div)
    else $error("prohibited divide code applied");
  property p_gap; $fell(cpu_clk_gate_o) |=> (!cpu_clk_gate_o) [*8]; endproperty
  a_gap: assert property (p_gap)
    else $error("clock gate reopened too soon");
  property p_sel; $changed({cpu_on_sub_o, main_clk_hi_o, cpu_div_o}) |-> !cpu_clk_gate_o;
  endproperty
  a_sel: assert property (p_sel)
    else $error("selection changed while the clock ran");
  property p_rst; $rose(arst_n_i) |-> ring_osc_run_o && !cpu_on_sub_o && !sub_crystal_osc_o;
  endproperty
  a_rst: assert property (p_rst)
    else $error("wrong clock state after reset release");
endmodule // clock_source_ctrl_props

bind clock_source_ctrl clock_source_ctrl_props u_props (.*);

// ### testbench/mcu_clock_source_control_bench.sv
// Purpose: Self-checking bench for the clock source control block.
// Assumes: Single AHB-Lite master; the slave ready is the bus ready.
// Notes:   Waits on the bus are bounded; a hang ends the run as a mismatch.
`timescale 1ns/1ps
module mcu_clock_source_control_bench;
  // ==========================================================
  // Stimulus and observed signals.
  logic        clk_i = 1'b0, arst_n_i = 1'b0, hsel_i, hwrite_i, stop_req_i, wake_i;
  logic [31:0] haddr_i, hwdata_i;
  logic [1:0]  htrans_i;
  logic [2:0]  hsize_i;
  wire  [31:0] hrdata_o;
  wire  [2:0]  cpu_div_o, settle_sel_o;
  wire         hreadyout_o, hresp_o, stop_mode_o, main_crystal_osc_o, main_ext_in_en_o;
  wire         ring_osc_run_o, sub_crystal_osc_o, sub_ext_in_en_o, main_clk_hi_o;
  wire         per_clk_hi_o, cpu_on_sub_o, cpu_clk_gate_o;
  wire         hready_i = hreadyout_o; // The one slave drives the bus ready.
  int          n_mismatch = 0, check_count = 0;
  logic [31:0] r; // Last read data.
  // Rows: address, write data, read mask, expected read.
  logic [31:0] rows [10] = '{32'h00000700, 32'h00040704, 32'h00050704, 32'h00070704,
    32'h00030703, 32'h00020702, 32'h00010701, 32'h14030703, 32'h18ffff00, 32'h04020200};
  // Sub pin cases: address, write data, expected {crystal, external}.
  logic [23:0] subs [6] = '{24'h101002, 24'h103001, 24'h102000, 24'h100000, 24'h004102,
    24'h000100};
  always #2 clk_i = ~clk_i; // 250 MHz.
  clock_source_ctrl uut (.*);
  // ==========================================================
  // Shared tasks.
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Waits for ready sampled high; a stuck bus ends the run.
  task automatic hwait;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 20);
    if (hreadyout_o !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    htrans_i <= 2'h2;
    hwait();
    htrans_i <= 2'h0;
    hwdata_i <= d;
    hwait();
    r = hrdata_o;
  endtask
  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input string nm, input logic [7:0] a, m, e);
    bus(1'b0, a, 32'h0);
    chk(nm, r & {24'h0, m}, {24'h0, e});
  endtask
  // ==========================================================
  // Main sequence.
  initial begin
    {hsel_i, hwrite_i, stop_req_i, wake_i, htrans_i, hsize_i} = '0;
    hsize_i = 3'h2;
    haddr_i = '0;
    hwdata_i = '0;
    wt(12);
    arst_n_i <= 1'b1;
    wt(1);
    chk("reset_outs", {ring_osc_run_o, cpu_div_o, sub_crystal_osc_o, sub_ext_in_en_o}, 32'h24);
    chk("bus_idle", {hreadyout_o, hresp_o, settle_sel_o}, 32'h15);
    rd("main_halt", 8'h0c, 8'h80, 8'h80);
    rd("ring_early", 8'h08, 8'h81, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i][31:24], rows[i][23:16]);
      rd("row", rows[i][31:24], rows[i][15:8], rows[i][7:0]);
      if (rows[i][31:24] == 8'h00) begin
        wt(30);
        chk("applied_div", {cpu_clk_gate_o, cpu_div_o}, {1'b1, rows[i][2:0]});
      end
      $display("row %0d done", i);
    end
    wt(520);
    rd("ring_stable", 8'h08, 8'h80, 8'h80);
    foreach (subs[i]) begin
      wr(subs[i][23:16], subs[i][15:8]);
      wt(3);
      chk("sub_pins", {sub_crystal_osc_o, sub_ext_in_en_o}, subs[i][1:0]);
    end
    wr(8'h00, 8'h51);
    rd("cls_early", 8'h00, 8'h20, 8'h00);
    wt(1);
    chk("gate_low", cpu_clk_gate_o, 0);
    wt(27);
    chk("cpu_sub", cpu_on_sub_o, 1);
    rd("sub_flag", 8'h00, 8'h20, 8'h20);
    wr(8'h00, 8'h01);
    wr(8'h10, 8'h40);
    wr(8'h0c, 8'h00);
    wt(30);
    chk("xtal_on", {cpu_on_sub_o, main_crystal_osc_o}, 1);
    wr(8'h04, 8'h04);
    wt(30);
    chk("per_hi", {main_clk_hi_o, per_clk_hi_o}, 1);
    wr(8'h04, 8'h05);
    wt(30);
    chk("all_hi", {main_clk_hi_o, per_clk_hi_o}, 3);
    rd("main_flag", 8'h04, 8'h02, 8'h02);
    wr(8'h08, 8'h01);
    wt(3);
    rd("ring_off", 8'h08, 8'h80, 8'h00);
    chk("ring_off", ring_osc_run_o, 0);
    wr(8'h08, 8'h00);
    wt(3);
    chk("ring_on", ring_osc_run_o, 1);
    wr(8'h04, 8'h00);
    wt(30);
    chk("ring_main", {main_clk_hi_o, per_clk_hi_o}, 0);
    wr(8'h0c, 8'h80);
    wt(3);
    chk("xtal_off", main_crystal_osc_o, 0);
    wr(8'h10, 8'hc0);
    wr(8'h0c, 8'h00);
    wt(3);
    chk("ext_on", {main_crystal_osc_o, main_ext_in_en_o}, 1);
    stop_req_i <= 1'b1;
    wt(1);
    stop_req_i <= 1'b0;
    wt(3);
    chk("stopped", {stop_mode_o, ring_osc_run_o, main_ext_in_en_o}, 4);
    wake_i <= 1'b1;
    wt(8);
    wake_i <= 1'b0;
    wt(4);
    chk("woken", {stop_mode_o, ring_osc_run_o, main_ext_in_en_o}, 3);
    $display("scenarios done");
    complete_run();
  end
endmodule // mcu_clock_source_control_bench
